// ===== ldac_cfg.svh
`ifndef LDAC_CFG_SVH
`define LDAC_CFG_SVH
// register byte addresses
`define LDAC_OFF_CTRL0     8'h00
`define LDAC_OFF_LEVEL     8'h04
`define LDAC_OFF_STATUS    8'h08
// control register zero fields
`define LDAC_BIT_ENABLE    7
`define LDAC_BIT_LPSIDE    6
`define LDAC_BIT_PINOE     5
`define LDAC_BIT_PSS_HI    3
`define LDAC_BIT_PSS_LO    2
`define LDAC_BIT_NSS       0
`define LDAC_CTRL0_MASK    8'hED
`define LDAC_LEVEL_MASK    8'h1F
// reset values
`define LDAC_CTRL0_RESET   8'h00
`define LDAC_LEVEL_RESET   8'h00
// switch controls as the cleared registers decode: lower end on ground, upper supply picked
`define LDAC_ANALOG_RESET  14'h0062
// ladder geometry
`define LDAC_CODE_BITS     5
`define LDAC_LEVELS        32
`define LDAC_CODE_MAX      5'h1F
`define LDAC_CODE_MIN      5'h00
// axi responses
`define LDAC_RESP_OKAY     2'h0
`define LDAC_RESP_SLVERR   2'h2
`endif

// ===== ldac_pkg.sv
package ldac_pkg;
  // positive source routing choices
  typedef enum logic [1:0] {
    LDAC_PSS_SUPPLY   = 2'b00,
    LDAC_PSS_EXTREF   = 2'b01,
    LDAC_PSS_FIXEDREF = 2'b10,
    LDAC_PSS_RESERVED = 2'b11
  } ldac_pss_t;

  // control register zero layout
  typedef struct packed {
    logic      ladderEnable;
    logic      lowPowerSideSelect;
    logic      pinOutputEnable;
    logic      unused4;
    ldac_pss_t positiveSourceSelect;
    logic      unused1;
    logic      negativeSourceSelect;
  } ldac_ctrl0_t;

  // analog switch controls toward the ladder
  typedef struct packed {
    logic [4:0] tapSelect;
    logic       ladderOn;
    logic       upperConnect;
    logic       lowerConnect;
    logic       upperSupply;
    logic       upperExtRef;
    logic       upperFixedRef;
    logic       lowerExtRef;
    logic       lowerGround;
    logic       pinDrive;
  } ldac_analog_t;
endpackage

// ===== ladder_dac_control.sv
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "ldac_cfg.svh"
module ladder_dac_control (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  clkEnable,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  sleepWake,
  input  wire logic                  pinDigitalIn,
  output logic                       pinDigitalRead,
  output logic                       pinDigitalOverride,
  output ldac_pkg::ldac_analog_t     analogCtrl,
  output logic                       refToComparator,
  output logic                       refToAdc,
  output logic                       refToCapSense
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  ldac_pkg::ldac_ctrl0_t ctrl0;
  logic [7:0]            levelReg;
  logic                  awHeld;
  logic                  wHeld;
  logic [7:0]            awAddr;
  logic [31:0]           wData;
  logic [3:0]            wStrb;
  logic                  pinSync1;
  logic                  pinSync2;
  logic                  wakeSeen;
  logic                  doWrite;
  logic [7:0]            readValue;
  logic [4:0]            levelCode;

  assign levelCode = levelReg[4:0];

  // ---------------------------------------------------------------
  // axi write path
  // ---------------------------------------------------------------
  // address and data are taken independently, in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = clkEnable && awHeld && wHeld && !s_axi_bvalid;

  // capture channels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else if (clkEnable) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response; unmapped or status address answers slverr
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LDAC_RESP_OKAY;
    end else if (clkEnable) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr[7:2] == `LDAC_OFF_CTRL0 >> 2 || awAddr[7:2] == `LDAC_OFF_LEVEL >> 2)
                        ? `LDAC_RESP_OKAY : `LDAC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; wake from sleep has no path into them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl0    <= `LDAC_CTRL0_RESET;
      levelReg <= `LDAC_LEVEL_RESET;
    end else if (doWrite && wStrb[0]) begin
      if (awAddr[7:2] == `LDAC_OFF_CTRL0 >> 2)
        ctrl0 <= wData[7:0] & `LDAC_CTRL0_MASK;
      if (awAddr[7:2] == `LDAC_OFF_LEVEL >> 2)
        levelReg <= wData[7:0] & `LDAC_LEVEL_MASK;
    end
  end

  // ---------------------------------------------------------------
  // axi read path
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // status word: bit0 wake seen since reset, bit1 pin override active
  always_comb begin
    readValue = 8'h00;
    case (s_axi_araddr[7:2])
      `LDAC_OFF_CTRL0 >> 2:  readValue = ctrl0;
      `LDAC_OFF_LEVEL >> 2:  readValue = levelReg;
      `LDAC_OFF_STATUS >> 2: readValue = {6'h00, analogCtrl.pinDrive, wakeSeen};
      default:               readValue = 8'h00;
    endcase
  end

  // read data register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LDAC_RESP_OKAY;
    end else if (clkEnable) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, readValue};
        s_axi_rresp  <= (s_axi_araddr[7:2] <= `LDAC_OFF_STATUS >> 2) ? `LDAC_RESP_OKAY : `LDAC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // sleep wake observation and pin input
  // ---------------------------------------------------------------
  // wake is a pin-level event so it is synchronised first
  logic wakeSync1;
  logic wakeSync2;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wakeSync1 <= 1'b0;
      wakeSync2 <= 1'b0;
      wakeSeen  <= 1'b0;
      pinSync1  <= 1'b0;
      pinSync2  <= 1'b0;
    end else if (clkEnable) begin
      wakeSync1 <= sleepWake;
      wakeSync2 <= wakeSync1;
      pinSync1  <= pinDigitalIn;
      pinSync2  <= pinSync1;
      if (wakeSync2)
        wakeSeen <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // analog control decode, registered one cycle after the write
  // ---------------------------------------------------------------
  ldac_pkg::ldac_analog_t next_analog;
  always_comb begin
    next_analog               = '0;
    next_analog.ladderOn      = ctrl0.ladderEnable;
    // enabled: tap follows code; disabled: tap parks at code, clamp cases below
    next_analog.tapSelect     = levelCode;
    // disabled: low-power side set drops the lower end, cleared drops the upper end; enabled keeps both ends
    next_analog.upperConnect  = ctrl0.lowPowerSideSelect || ctrl0.ladderEnable;
    next_analog.lowerConnect  = !ctrl0.lowPowerSideSelect || ctrl0.ladderEnable;
    if (!ctrl0.ladderEnable && ctrl0.lowPowerSideSelect && levelCode == `LDAC_CODE_MAX)
      next_analog.upperConnect = 1'b1;
    if (!ctrl0.ladderEnable && !ctrl0.lowPowerSideSelect && levelCode == `LDAC_CODE_MIN)
      next_analog.lowerConnect = 1'b1;
    case (ctrl0.positiveSourceSelect)
      ldac_pkg::LDAC_PSS_SUPPLY:   next_analog.upperSupply   = 1'b1;
      ldac_pkg::LDAC_PSS_EXTREF:   next_analog.upperExtRef   = 1'b1;
      ldac_pkg::LDAC_PSS_FIXEDREF: next_analog.upperFixedRef = 1'b1;
      default:                     next_analog.upperSupply   = 1'b0;  // reserved: no source
    endcase
    next_analog.lowerExtRef   = ctrl0.negativeSourceSelect;
    next_analog.lowerGround   = !ctrl0.negativeSourceSelect;
    next_analog.pinDrive      = ctrl0.pinOutputEnable;
  end

  // the one-cycle lag keeps switch changes glitch free
  always_ff @(posedge clk or posedge reset) begin
    // reset parks the switches at the decode of the cleared registers,
    // so nothing moves at the first enabled edge and one lower source is always picked
    if (reset)
      analogCtrl <= `LDAC_ANALOG_RESET;
    else if (clkEnable)
      analogCtrl <= next_analog;
  end

  // ---------------------------------------------------------------
  // pin override and consumers
  // ---------------------------------------------------------------
  assign pinDigitalOverride = analogCtrl.pinDrive;
  assign pinDigitalRead     = analogCtrl.pinDrive ? 1'b0 : pinSync2;
  // taps always feed the on-chip users; they choose by their own selects
  assign refToComparator    = analogCtrl.ladderOn || analogCtrl.upperConnect || analogCtrl.lowerConnect;
  assign refToAdc           = refToComparator;
  assign refToCapSense      = refToComparator;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence ctrlWrite_s;
    doWrite && wStrb[0] && awAddr == `LDAC_OFF_CTRL0;
  endsequence

  tap_follows_code_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable |=> analogCtrl.tapSelect == $past(levelCode))
    else $error("tap select does not follow level code");
  enable_lag_a: assert property (@(posedge clk) disable iff (reset)
    ctrlWrite_s ##1 clkEnable |=> analogCtrl.ladderOn == $past(ctrl0.ladderEnable))
    else $error("enable not applied one cycle after write");
  lowpower_side_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable && !ctrl0.ladderEnable && ctrl0.lowPowerSideSelect && levelCode != `LDAC_CODE_MAX
    |=> !analogCtrl.lowerConnect)
    else $error("lower source not dropped");
  upper_clamp_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable && !ctrl0.ladderEnable && ctrl0.lowPowerSideSelect && levelCode == `LDAC_CODE_MAX
    |=> analogCtrl.upperConnect && analogCtrl.tapSelect == `LDAC_CODE_MAX)
    else $error("upper clamp wrong");
  lower_clamp_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable && !ctrl0.ladderEnable && !ctrl0.lowPowerSideSelect && levelCode == `LDAC_CODE_MIN
    |=> analogCtrl.lowerConnect && !analogCtrl.upperConnect)
    else $error("lower clamp wrong");
  pos_select_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable && ctrl0.positiveSourceSelect == ldac_pkg::LDAC_PSS_FIXEDREF
    |=> analogCtrl.upperFixedRef && !analogCtrl.upperSupply && !analogCtrl.upperExtRef)
    else $error("positive source routing wrong");
  neg_select_a: assert property (@(posedge clk) disable iff (reset)
    analogCtrl.lowerExtRef != analogCtrl.lowerGround)
    else $error("negative source routing wrong");
  pin_read_a: assert property (@(posedge clk) disable iff (reset)
    analogCtrl.pinDrive |-> !pinDigitalRead && pinDigitalOverride)
    else $error("pin read not zero under override");
  wake_hold_a: assert property (@(posedge clk) disable iff (reset)
    !doWrite |=> ctrl0 == $past(ctrl0))
    else $error("control zero changed without write");
  unimpl_zero_a: assert property (@(posedge clk) disable iff (reset)
    levelReg[7:5] == 3'h0 && !ctrl0.unused4 && !ctrl0.unused1)
    else $error("unimplemented bits set");
  level_range_a: assert property (@(posedge clk) disable iff (reset)
    doWrite && wStrb[0] && awAddr == `LDAC_OFF_LEVEL |=> levelCode == $past(wData[4:0]))
    else $error("level code not stored");
  enable_drive_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable && ctrl0.ladderEnable |=> analogCtrl.ladderOn && analogCtrl.upperConnect)
    else $error("enable did not turn ladder on");
  pin_enable_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable && ctrl0.pinOutputEnable |=> analogCtrl.pinDrive)
    else $error("pin drive missing");
  // twin of the lower side check; a swapped pair of switches trips one of them
  upper_drop_a: assert property (@(posedge clk) disable iff (reset)
    clkEnable && !ctrl0.ladderEnable && !ctrl0.lowPowerSideSelect
    |=> !analogCtrl.upperConnect && analogCtrl.lowerConnect)
    else $error("upper source not dropped");
  // an enabled ladder is offered to every on-chip user at once
  refs_offered_a: assert property (@(posedge clk) disable iff (reset)
    analogCtrl.ladderOn |-> refToComparator && refToAdc && refToCapSense)
    else $error("reference not offered to all users");
  // no disable here, so the cleared state itself is seen at release
  reset_state_a: assert property (@(posedge clk)
    $fell(reset) |-> !analogCtrl.ladderOn && !analogCtrl.pinDrive && levelCode == `LDAC_CODE_MIN)
    else $error("reset left converter state");
  // only byte lane zero carries register bits
  read_upper_zero_a: assert property (@(posedge clk) disable iff (reset)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

endmodule

// ===== ldac_ladder_model.sv
`timescale 1ns/10ps
module ldac_ladder_model #(
  parameter int SupplyMv = 3300,
  parameter int ExtPosMv = 2048,
  parameter int FixedMv  = 1024,
  parameter int ExtNegMv = 256
) (
  input  wire logic                   clk,
  input  wire logic                   padValue,
  input  wire ldac_pkg::ldac_analog_t analogCtrl,
  output logic                        pinDigitalIn,
  output int                          levelX32
);
  int   upMv;
  int   loMv;
  logic toggle = 1'b0;
  // --------------------------------
  // ladder ends, -1 marks a floating end
  // --------------------------------
  always_comb begin
    upMv = -1;
    loMv = -1;
    if (analogCtrl.upperConnect && analogCtrl.upperSupply) upMv = SupplyMv;
    if (analogCtrl.upperConnect && analogCtrl.upperExtRef) upMv = ExtPosMv;
    if (analogCtrl.upperConnect && analogCtrl.upperFixedRef) upMv = FixedMv;
    if (analogCtrl.lowerConnect && analogCtrl.lowerExtRef) loMv = ExtNegMv;
    if (analogCtrl.lowerConnect && analogCtrl.lowerGround) loMv = 0;
  end
  // tap level in 1/32 mV; an idle ladder follows its only connected end
  always_comb begin
    if (analogCtrl.ladderOn && upMv >= 0 && loMv >= 0) begin
      levelX32 = loMv * 32 + (upMv - loMv) * int'(analogCtrl.tapSelect);
    end else if (!analogCtrl.ladderOn && upMv >= 0 && loMv < 0) begin
      levelX32 = upMv * 32;
    end else if (!analogCtrl.ladderOn && loMv >= 0 && upMv < 0) begin
      levelX32 = loMv * 32;
    end else begin
      levelX32 = -1;
    end
  end
  // analog level on the pad gives the digital detector a changing pattern
  always_ff @(posedge clk) toggle <= ~toggle;
  assign pinDigitalIn = analogCtrl.pinDrive ? toggle : padValue;
endmodule

// ===== test_ladder_dac_control.sv
`timescale 1ns/10ps
`include "ldac_cfg.svh"
module test_ladder_dac_control;
  localparam int SupMv = 3300, PosMv = 2048, FixMv = 1024, NegMv = 256;
  logic clk, reset, clkEnable, sleepWake, padValue, pinDigitalIn, pinDigitalRead, pinDigitalOverride;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic refToComparator, refToAdc, refToCapSense;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, c, l;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  ldac_pkg::ldac_analog_t analogCtrl;
  int levelX32, num_errors, comparisons, seed;

  ladder_dac_control dut (
    .clk(clk), .reset(reset), .clkEnable(clkEnable),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sleepWake(sleepWake), .pinDigitalIn(pinDigitalIn), .pinDigitalRead(pinDigitalRead),
    .pinDigitalOverride(pinDigitalOverride), .analogCtrl(analogCtrl),
    .refToComparator(refToComparator), .refToAdc(refToAdc), .refToCapSense(refToCapSense));
  ldac_ladder_model #(.SupplyMv(SupMv), .ExtPosMv(PosMv), .FixedMv(FixMv), .ExtNegMv(NegMv)) model (
    .clk(clk), .padValue(padValue), .analogCtrl(analogCtrl), .pinDigitalIn(pinDigitalIn), .levelX32(levelX32));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // --------------------------------
  // checking and reporting
  // --------------------------------
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // expected tap level in 1/32 mV from the register fields
  function automatic int expX32(input logic [7:0] cv, input logic [4:0] code);
    int up, lo;
    up = (cv[3:2] == 2'b00) ? SupMv : (cv[3:2] == 2'b01) ? PosMv : FixMv;
    lo = cv[0] ? NegMv : 0;
    if (cv[7]) return lo * 32 + (up - lo) * int'(code);
    return cv[6] ? up * 32 : lo * 32;
  endfunction
  // --------------------------------
  // register bus master, waits bounded
  // --------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wstrb <= s;
    s_axi_wdata <= {24'h00_0000, d}; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 40) begin chk(0, "write timeout"); finish_test(); end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rdReg(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 40) begin chk(0, "read timeout"); finish_test(); end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // program both registers and judge the analog controls; tap only when enabled, sources only on a connected end
  task automatic cfg(input logic [7:0] cv, input logic [7:0] lv);
    logic en, lps;
    logic [4:0] code;
    en = cv[7]; lps = cv[6]; code = lv[4:0];
    wr(`LDAC_OFF_CTRL0, cv, 4'h1);
    chk(resp === `LDAC_RESP_OKAY, "ctrl write response");
    wr(`LDAC_OFF_LEVEL, lv, 4'h1);
    @(negedge clk);
    if (en) chk(analogCtrl.tapSelect === code, "tap late after write");
    repeat (4) @(posedge clk);
    chk(analogCtrl.ladderOn === en, "ladder enable");
    chk(analogCtrl.upperConnect === (en | lps) && analogCtrl.lowerConnect === (en | !lps), "side");
    if (analogCtrl.upperConnect === 1'b1) chk({analogCtrl.upperSupply, analogCtrl.upperExtRef,
      analogCtrl.upperFixedRef} === {cv[3:2] == 2'b00, cv[3:2] == 2'b01, cv[3:2] == 2'b10}, "upper");
    if (analogCtrl.lowerConnect === 1'b1) chk({analogCtrl.lowerExtRef, analogCtrl.lowerGround} === {cv[0], !cv[0]}, "lower");
    if (en && cv[3:2] != 2'b11) chk(analogCtrl.tapSelect === code && levelX32 == expX32(cv, code), "level");
    if (en) chk({refToComparator, refToAdc, refToCapSense} === 3'b111, "reference offered");
    if (!en && lps && code == 5'h1F && cv[3:2] != 2'b11) chk(levelX32 == expX32(cv, code), "clamp high");
    if (!en && !lps && code == 5'h00) chk(levelX32 == expX32(cv, code), "clamp low");
    chk(analogCtrl.pinDrive === cv[5] && pinDigitalOverride === cv[5], "pin drive");
    chk(pinDigitalRead === (cv[5] ? 1'b0 : padValue), "pin read");
    rdReg(`LDAC_OFF_CTRL0);
    chk(rd === {24'h00_0000, cv & `LDAC_CTRL0_MASK}, "ctrl readback");
    rdReg(`LDAC_OFF_LEVEL);
    chk(rd === {27'h000_0000, code}, "level readback");
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    seed = 32'hb574_e60f;
    {reset, clkEnable} = 2'b11;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleepWake, padValue} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0_0000_0000_0000;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rdReg(`LDAC_OFF_CTRL0);
    chk(rd === 32'h0000_0000, "ctrl reset value");
    rdReg(`LDAC_OFF_LEVEL);
    chk(rd === 32'h0000_0000, "level reset value");
    chk(analogCtrl.ladderOn === 1'b0 && analogCtrl.pinDrive === 1'b0, "reset outputs");
    $display("test reset done");
    // high clamp for every positive source, low clamp for both negative sources, then enabled code extremes
    for (int i = 0; i < 4; i++) cfg({4'b0110, 2'(i), 2'b00}, 8'hFF);
    for (int i = 0; i < 2; i++) cfg({7'h00, 1'(i)}, 8'hE0);
    cfg(8'h80, 8'h1F);
    cfg(8'hC5, 8'h00);
    $display("test corners done");
    for (int i = 0; i < 30; i++) begin
      c = 8'($random(seed));
      l = 8'($random(seed));
      padValue <= 1'($random(seed));
      cfg(c, l);
    end
    $display("test random done");
    wr(8'h0C, 8'hFF, 4'h1);
    chk(resp === `LDAC_RESP_SLVERR, "unmapped write response");
    rdReg(8'h10);
    chk(resp === `LDAC_RESP_SLVERR && rd === 32'h0000_0000, "unmapped read");
    // software turns the ladder off before sleep, pin output left on
    cfg(8'h25, 8'h11);
    wr(`LDAC_OFF_CTRL0, 8'h00, 4'h0);
    chk(resp === `LDAC_RESP_OKAY, "masked write response");
    sleepWake <= 1'b1;
    repeat (3) @(posedge clk);
    sleepWake <= 1'b0;
    repeat (4) @(posedge clk);
    rdReg(`LDAC_OFF_CTRL0);
    chk(rd === 32'h0000_0025, "ctrl kept over wake and masked write");
    rdReg(`LDAC_OFF_STATUS);
    chk(rd === 32'h0000_0003, "status wake and pin drive");
    $display("test bus and wake done");
    cfg(8'hA0, 8'h1F);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(analogCtrl.ladderOn === 1'b0 && analogCtrl.pinDrive === 1'b0, "mid reset outputs");
    rdReg(`LDAC_OFF_LEVEL);
    chk(rd === 32'h0000_0000, "mid reset level");
    $display("test mid reset done");
    finish_test();
  end
endmodule
